// ---- rasc_pkg.sv ----
package rasc_pkg;
   // Register port geometry
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned WORD_W = 24;
   localparam int unsigned SPACING_W = 16;

   // Register offsets
   localparam logic [5:0] NODE_ID_FILTER_OFS = 6'h09;
   localparam logic [5:0] HOP_INDEX_OFS = 6'h0a;
   localparam logic [5:0] SYNTH_CONTROL_IF_OFS = 6'h0b;
   localparam logic [5:0] SYNTH_CONTROL_OFFSET_OFS = 6'h0c;
   localparam logic [5:0] BASE_WORD_HIGH_OFS = 6'h0d;
   localparam logic [5:0] BASE_WORD_MID_OFS = 6'h0e;
   localparam logic [5:0] BASE_WORD_LOW_OFS = 6'h0f;

   // Reset values
   localparam logic [7:0] NODE_ID_RST = 8'h00;
   localparam logic [7:0] HOP_INDEX_RST = 8'h00;
   localparam logic [4:0] IF_WORD_RST = 5'h0f;
   localparam logic [7:0] OFFSET_RST = 8'h00;
   localparam logic [5:0] BASE_HIGH_RST = 6'h1e;
   localparam logic [7:0] BASE_MID_RST = 8'hc4;
   localparam logic [7:0] BASE_LOW_RST = 8'hec;

   // Field widths of partly writable registers
   localparam int unsigned IF_W = 5;
   localparam int unsigned BASE_HIGH_W = 6;

   // Scaling into base-word steps (fxosc/2^16)
   localparam int unsigned OFFSET_SHIFT = 2;  // 2^16 / 2^14
   localparam int unsigned IF_SHIFT = 6;      // 2^16 / 2^10

   // Broadcast addresses
   localparam logic [7:0] BCAST_ZERO = 8'h00;
   localparam logic [7:0] BCAST_ONES = 8'hff;

   // Address-check modes
   typedef enum logic [1:0] {
      CHECK_OFF = 2'h0,
      CHECK_NO_BCAST = 2'h1,
      CHECK_BCAST_ZERO = 2'h2,
      CHECK_BCAST_BOTH = 2'h3
   } rasc_check_mode_t;
endpackage

// ---- rasc_config.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Hold 8-bit node identifier; packet filter compares it; 0x00/0xFF optional broadcast.
// - Unsigned hop index times channel spacing is added to the base word.
// - In receive, subtract IF word from base; IF word drives the mixer.
// - Signed 8-bit tuning offset is added to base word, step fxosc/2^14.
// - Calibration strobe or frequency compensation adds carrier error into tuning offset.
// - Base word bits 23:22 read zero and cannot be written.
// - Base word steps fxosc/2^16; high register bits 5:0 give word bits 21:16.
// - Middle and low registers give word bits 15:8 and 7:0, both read/write.
// - Two-bit check mode: off, no broadcast, accept 0x00, accept 0x00 and 0xFF.
module rasc_config (
   input wire logic clock,                        // 100 MHz core clock
   input wire logic resetn,                       // Synchronous reset, active low
   input wire logic clk_en,                       // Freezes all state when low
   input wire logic reg_wr_en,                    // Register write strobe
   input wire logic reg_rd_en,                    // Register read strobe
   input wire logic [5:0] reg_addr,               // Register offset
   input wire logic [7:0] reg_wdata,              // Write data
   output logic [7:0] reg_rdata,                  // Read data, held until next read
   input wire logic rx_mode,                      // Receiver active
   input wire logic [15:0] channel_spacing,       // Spacing in base-word steps
   input wire logic [7:0] carrier_error_estimate, // Signed carrier error
   input wire logic offset_calibrate_strobe,      // One-cycle calibration command
   input wire logic afc_update,                   // One-cycle compensation event
   input wire logic [1:0] filter_check_mode,      // Address-check mode
   input wire logic [7:0] pkt_addr,               // Received packet address
   input wire logic pkt_addr_valid,               // Packet address present
   output logic addr_accept,                      // Packet passes the filter
   output logic addr_result_valid,                // One-cycle result strobe
   output logic [23:0] synth_synth_base_word_word,           // Composed synthesizer word
   output logic [4:0] intermediate_tone_word      // Mixer steering word
);
   //////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] node_id_q, node_id_d;
   logic [7:0] hop_index_q, hop_index_d;
   logic [4:0] if_word_q, if_word_d;
   logic [7:0] tuning_offset_q, tuning_offset_d;
   logic [5:0] base_high_q, base_high_d;
   logic [7:0] base_mid_q, base_mid_d;
   logic [7:0] base_low_q, base_low_d;
   logic [7:0] rdata_q, rdata_d;
   logic wr;
   logic add_err;

   assign wr = reg_wr_en & clk_en;
   assign add_err = offset_calibrate_strobe | afc_update;

   // Next register values; upper bits of partial registers are dropped
   always_comb begin
      node_id_d = node_id_q;
      hop_index_d = hop_index_q;
      if_word_d = if_word_q;
      tuning_offset_d = tuning_offset_q;
      base_high_d = base_high_q;
      base_mid_d = base_mid_q;
      base_low_d = base_low_q;
      if (wr) begin
         case (reg_addr)
            rasc_pkg::NODE_ID_FILTER_OFS: node_id_d = reg_wdata;
            rasc_pkg::HOP_INDEX_OFS: hop_index_d = reg_wdata;
            rasc_pkg::SYNTH_CONTROL_IF_OFS: if_word_d = reg_wdata[rasc_pkg::IF_W-1:0];
            rasc_pkg::SYNTH_CONTROL_OFFSET_OFS: tuning_offset_d = reg_wdata;
            rasc_pkg::BASE_WORD_HIGH_OFS: base_high_d = reg_wdata[rasc_pkg::BASE_HIGH_W-1:0];
            rasc_pkg::BASE_WORD_MID_OFS: base_mid_d = reg_wdata;
            rasc_pkg::BASE_WORD_LOW_OFS: base_low_d = reg_wdata;
            default: ;
         endcase
      end
      // Error accumulates onto a same-cycle write so no event is lost
      if (add_err) begin
         tuning_offset_d = tuning_offset_d + carrier_error_estimate;
      end
   end

   // Read mux; reserved and unmapped bits read as zero
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_en) begin
         case (reg_addr)
            rasc_pkg::NODE_ID_FILTER_OFS: rdata_d = node_id_q;
            rasc_pkg::HOP_INDEX_OFS: rdata_d = hop_index_q;
            rasc_pkg::SYNTH_CONTROL_IF_OFS: rdata_d = {3'h0, if_word_q};
            rasc_pkg::SYNTH_CONTROL_OFFSET_OFS: rdata_d = tuning_offset_q;
            rasc_pkg::BASE_WORD_HIGH_OFS: rdata_d = {2'h0, base_high_q};
            rasc_pkg::BASE_WORD_MID_OFS: rdata_d = base_mid_q;
            rasc_pkg::BASE_WORD_LOW_OFS: rdata_d = base_low_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Register bank
   always_ff @(posedge clock) begin
      if (!resetn) begin
         node_id_q <= rasc_pkg::NODE_ID_RST;
         hop_index_q <= rasc_pkg::HOP_INDEX_RST;
         if_word_q <= rasc_pkg::IF_WORD_RST;
         tuning_offset_q <= rasc_pkg::OFFSET_RST;
         base_high_q <= rasc_pkg::BASE_HIGH_RST;
         base_mid_q <= rasc_pkg::BASE_MID_RST;
         base_low_q <= rasc_pkg::BASE_LOW_RST;
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         node_id_q <= node_id_d;
         hop_index_q <= hop_index_d;
         if_word_q <= if_word_d;
         tuning_offset_q <= tuning_offset_d;
         base_high_q <= base_high_d;
         base_mid_q <= base_mid_d;
         base_low_q <= base_low_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   //////////////////////////////////////////////////////////////////////////
   // Frequency composition, one cycle behind the registers
   logic [23:0] base_word;
   logic [23:0] hop_term;
   logic [23:0] offset_term;
   logic [23:0] if_term;
   logic [23:0] synth_base_word_q, synth_base_word_d;
   logic [4:0] tone_q, tone_d;

   assign base_word = {2'h0, base_high_q, base_mid_q, base_low_q};
   // Both factors widened first so the product keeps all 24 bits
   assign hop_term = 24'(hop_index_q) * 24'(channel_spacing);
   // Sign-extend before scaling so negative offsets pull the word down
   assign offset_term = 24'($signed(tuning_offset_q)) << rasc_pkg::OFFSET_SHIFT;
   assign if_term = 24'(if_word_q) << rasc_pkg::IF_SHIFT;

   // Word wraps modulo 2^24; software keeps settings in range
   always_comb begin
      synth_base_word_d = base_word + hop_term + offset_term;
      if (rx_mode) begin
         synth_base_word_d = synth_base_word_d - if_term;
      end
      tone_d = if_word_q;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         synth_base_word_q <= 24'h000000;
         tone_q <= 5'h00;
      end else if (clk_en) begin
         synth_base_word_q <= synth_base_word_d;
         tone_q <= tone_d;
      end
   end

   assign synth_synth_base_word_word = synth_base_word_q;
   assign intermediate_tone_word = tone_q;

   //////////////////////////////////////////////////////////////////////////
   // Packet address filter
   logic accept_q, accept_d;
   logic avalid_q, avalid_d;
   logic id_hit;

   assign id_hit = (pkt_addr == node_id_q);

   always_comb begin
      avalid_d = pkt_addr_valid;
      case (rasc_pkg::rasc_check_mode_t'(filter_check_mode))
         rasc_pkg::CHECK_OFF: accept_d = 1'b1;
         rasc_pkg::CHECK_NO_BCAST: accept_d = id_hit;
         rasc_pkg::CHECK_BCAST_ZERO: accept_d = id_hit | (pkt_addr == rasc_pkg::BCAST_ZERO);
         rasc_pkg::CHECK_BCAST_BOTH: accept_d = id_hit | (pkt_addr == rasc_pkg::BCAST_ZERO)
                                                | (pkt_addr == rasc_pkg::BCAST_ONES);
         default: accept_d = 1'b0;
      endcase
      if (!pkt_addr_valid) begin
         accept_d = accept_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         accept_q <= 1'b0;
         avalid_q <= 1'b0;
      end else if (clk_en) begin
         accept_q <= accept_d;
         avalid_q <= avalid_d;
      end
   end

   assign addr_accept = accept_q;
   assign addr_result_valid = avalid_q;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   node_write_a: assert property (@(posedge clock) disable iff (!resetn)
      wr && reg_addr == rasc_pkg::NODE_ID_FILTER_OFS |=> node_id_q == $past(reg_wdata))
      else $error("node id not written");
   // Word checks skip the release edge, where the word flop was still cleared
   hop_compose_a: assert property (@(posedge clock) disable iff (!resetn)
      resetn && clk_en && !rx_mode
      |=> synth_base_word_q == $past(base_word + offset_term)
                    + 24'($past(hop_index_q)) * 24'($past(channel_spacing)))
      else $error("hop term not added");
   rx_if_sub_a: assert property (@(posedge clock) disable iff (!resetn)
      resetn && clk_en && rx_mode
      |=> synth_base_word_q == $past(base_word + hop_term + offset_term)
                    - 24'($past(if_word_q)) * (24'h1 << rasc_pkg::IF_SHIFT))
      else $error("receive word lacks IF subtraction");
   offset_add_a: assert property (@(posedge clock) disable iff (!resetn)
      resetn && clk_en && !rx_mode
      |=> synth_base_word_q == $past(base_word + hop_term)
                    + 24'($signed($past(tuning_offset_q))) * (24'h1 << rasc_pkg::OFFSET_SHIFT))
      else $error("transmit word wrong");
   cal_accum_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && (offset_calibrate_strobe || afc_update) && !reg_wr_en
      |=> tuning_offset_q == 8'($past(tuning_offset_q) + $past(carrier_error_estimate)))
      else $error("calibration not accumulated");
   high_bits_zero_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && reg_rd_en && reg_addr == rasc_pkg::BASE_WORD_HIGH_OFS
      |=> reg_rdata[7:6] == 2'h0)
      else $error("base word top bits not zero");
   base_word_map_a: assert property (@(posedge clock) disable iff (!resetn)
      wr && reg_addr == rasc_pkg::BASE_WORD_MID_OFS |=> base_word[15:8] == $past(reg_wdata))
      else $error("middle byte not mapped");
   bcast_mode_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && pkt_addr_valid && filter_check_mode == rasc_pkg::CHECK_NO_BCAST
      && pkt_addr != node_id_q
      |=> !addr_accept && addr_result_valid)
      else $error("foreign address accepted");
   reserved_if_a: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && reg_rd_en && reg_addr == rasc_pkg::SYNTH_CONTROL_IF_OFS
      |=> reg_rdata[7:5] == 3'h0)
      else $error("reserved bits not zero");
endmodule

// ---- rasc_host.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Host side of the register port: one-cycle strobes, changed just after an edge
module rasc_host (
   input wire logic clock,   // Core clock
   output logic wr_en,       // Write strobe
   output logic rd_en,       // Read strobe
   output logic [5:0] addr,  // Register offset
   output logic [7:0] wdata  // Write data
);
   // Idle port at time zero
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 6'h00;
      wdata = 8'h00;
   end

   // Write one byte; data is scrambled afterwards so stale values never match
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      wdata <= ~d;
   endtask

   // Read one byte; caller samples the data after the taking edge
   task automatic rd(input logic [5:0] a);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      addr <= ~a;
   endtask
endmodule

// ---- radio_address_and_synth_config_test.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module radio_address_and_synth_config_test;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic rx_mode = 1'b0;
   logic [15:0] channel_spacing = 16'h0100;
   logic [7:0] carrier_error_estimate = 8'h05;
   logic offset_calibrate_strobe = 1'b0;
   logic afc_update = 1'b0;
   logic [1:0] filter_check_mode = 2'h0;
   logic [7:0] pkt_addr = 8'h00;
   logic pkt_addr_valid = 1'b0;
   logic reg_wr_en, reg_rd_en, addr_accept, addr_result_valid;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [23:0] synth_synth_base_word_word;
   logic [4:0] intermediate_tone_word;
   int failures = 0;
   int checked = 0;
   // Offset, write data, expected readback
   logic [21:0] rows [8] = '{{6'h09, 8'ha5, 8'ha5}, {6'h0a, 8'h03, 8'h03},
      {6'h0b, 8'hff, 8'h1f}, {6'h0c, 8'hfe, 8'hfe}, {6'h0d, 8'hff, 8'h3f},
      {6'h0e, 8'h12, 8'h12}, {6'h0f, 8'h34, 8'h34}, {6'h20, 8'h55, 8'h00}};
   // Check mode, packet address, expected accept (node id is 0xa5)
   logic [10:0] filt [7] = '{{2'h0, 8'h12, 1'b1}, {2'h1, 8'ha5, 1'b1}, {2'h1, 8'h00, 1'b0},
      {2'h2, 8'h00, 1'b1}, {2'h2, 8'hff, 1'b0}, {2'h3, 8'hff, 1'b1}, {2'h3, 8'h12, 1'b0}};
   logic [7:0] rst_vals [7] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec};

   // 100 MHz clock
   always #5 clock = ~clock;

   rasc_config rasc_config_inst (.clock(clock), .resetn(resetn), .clk_en(clk_en),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_mode(rx_mode),
      .channel_spacing(channel_spacing), .carrier_error_estimate(carrier_error_estimate),
      .offset_calibrate_strobe(offset_calibrate_strobe), .afc_update(afc_update),
      .filter_check_mode(filter_check_mode), .pkt_addr(pkt_addr),
      .pkt_addr_valid(pkt_addr_valid), .addr_accept(addr_accept),
      .addr_result_valid(addr_result_valid), .synth_synth_base_word_word(synth_synth_base_word_word),
      .intermediate_tone_word(intermediate_tone_word));
   rasc_host rasc_host_inst (.clock(clock), .wr_en(reg_wr_en), .rd_en(reg_rd_en),
      .addr(reg_addr), .wdata(reg_wdata));

   //////////////////////////////////////////////////////////////////////////////
   // Compare and count; case inequality so unknowns never pass
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Read through the host model, sample once the data has landed
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clock);
      rasc_host_inst.rd(a);
      #1 check("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, exp});
   endtask

   task automatic print_verdict();
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clock);
         rasc_host_inst.wr(rows[i][21:16], rows[i][15:8]);
         rd_chk(rows[i][21:16], rows[i][7:0]);
      end
      // Word is base 0x3f1234, plus three hops, minus two offset steps
      repeat (2) @(posedge clock);
      #1 check("word", synth_synth_base_word_word, 24'h3f1234 + 24'h000300 - 24'h000008);
      @(posedge clock);
      rx_mode <= 1'b1;
      repeat (2) @(posedge clock);
      #1 check("word", synth_synth_base_word_word, 24'h3f152c - 24'h0007c0);
      check("tone", {19'h0, intermediate_tone_word}, 24'h00001f);
      // Strobe, compensation, then both: each pass adds the estimate once
      for (int k = 1; k < 4; k++) begin
         @(posedge clock);
         offset_calibrate_strobe <= k[0];
         afc_update <= k[1];
         @(posedge clock);
         offset_calibrate_strobe <= 1'b0;
         afc_update <= 1'b0;
         rd_chk(rasc_pkg::SYNTH_CONTROL_OFFSET_OFS, 8'hfe + 8'(5 * k));
      end
      // Write and strobe together: nothing is lost
      @(posedge clock);
      offset_calibrate_strobe <= 1'b1;
      rasc_host_inst.wr(rasc_pkg::SYNTH_CONTROL_OFFSET_OFS, 8'h10);
      offset_calibrate_strobe <= 1'b0;
      rd_chk(rasc_pkg::SYNTH_CONTROL_OFFSET_OFS, 8'h15);
      // A write while frozen must not land
      @(posedge clock);
      clk_en <= 1'b0;
      rasc_host_inst.wr(rasc_pkg::NODE_ID_FILTER_OFS, 8'h00);
      clk_en <= 1'b1;
      rd_chk(rasc_pkg::NODE_ID_FILTER_OFS, 8'ha5);
      foreach (filt[i]) begin
         @(posedge clock);
         {filter_check_mode, pkt_addr} <= filt[i][10:1];
         pkt_addr_valid <= 1'b1;
         @(posedge clock);
         pkt_addr_valid <= 1'b0;
         #1 check("filter", {22'h0, addr_result_valid, addr_accept}, {22'h0, 1'b1, filt[i][0]});
         // Valid lasts one cycle, the verdict stays until the next address
         @(posedge clock);
         #1 check("filter hold", {22'h0, addr_result_valid, addr_accept}, {22'h0, 1'b0, filt[i][0]});
      end
      // Second reset in mid-run restores every register
      @(posedge clock);
      resetn <= 1'b0;
      rx_mode <= 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      foreach (rst_vals[i]) begin
         rd_chk(6'(9 + i), rst_vals[i]);
      end
      #1 check("word", synth_synth_base_word_word, 24'h1ec4ec);
      check("tone", {19'h0, intermediate_tone_word}, 24'h00000f);
      print_verdict();
   end

   // Watchdog; the whole run needs about a hundred cycles
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
endmodule
